// *** verilog/secl_loader_top.sv ***
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module secl_loader_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic master_slow_mode_strap,
	input wire logic [3:0] switch_operating_mode,
	input wire logic [3:0] master_eeprom_addr_pins,
	input wire logic hot_reset,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic reset_halt_bit
);
	logic [11:0] raw;
	logic [11:0] s1_ff;
	logic [11:0] s2_ff;
	logic [11:0] s3_ff;
	logic [11:0] cln_ff;
	logic hot_d_ff;
	logic [2:0] boot_ff;
	logic boot_go;
	logic ld_start;
	logic acc_go;
	secl_pkg::secl_txn_t txn_ff;
	secl_pkg::secl_prs_t prs_ff;
	logic ld_mode_ff;
	logic wait_ff;
	logic [15:0] ee_addr_ff;
	logic [7:0] csum_ff;
	logic [7:0] sum_n;
	logic [13:0] blk_addr_ff;
	logic [13:0] blk_idx;
	logic [15:0] cnt_ff;
	logic [31:0] data_ff;
	logic [1:0] bpos_ff;
	logic ld_we_ff;
	logic [7:0] ld_waddr_ff;
	logic [31:0] ld_wdata_ff;
	logic ev_done_ff;
	logic ev_cs_ff;
	logic ev_unmapped_write_flag_ff;
	logic ev_na_ff;
	logic ev_la_ff;
	logic ev_halt_ff;
	logic ev_acc_ff;
	logic [4:0] stat_ff;
	logic [4:0] set_vec;
	logic [4:0] clr_vec;
	logic [15:0] master_clock_prescaler;
	logic ick_ff;
	logic split_ff;
	logic acc_op_ff;
	logic [7:0] acc_data_ff;
	logic [7:0] acc_rd_ff;
	logic acc_done_ff;
	logic reg_acc;
	logic is_mem;
	logic mapped;
	logic blocked;
	logic reg_wr;
	logic [31:0] rd_mux;
	logic mem_we;
	logic [7:0] mem_waddr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic [1:0] eng_cmd;
	logic [7:0] eng_wdata;
	logic eng_ack;
	logic eng_go;
	logic eng_idle;
	logic eng_done;
	logic [7:0] eng_rdata;
	logic eng_nack;
	logic eng_lost;
	logic [7:0] dev_byte;

	// pins and straps: three flops, a change counts once stages two and three agree
	assign raw = {hot_reset, master_slow_mode_strap, switch_operating_mode,
		master_eeprom_addr_pins, scl_in, sda_in};
	generate
		for (genvar i = 0; i < secl_pkg::SYNC_W; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					s1_ff[i] <= secl_pkg::SYNC_RST[i];
					s2_ff[i] <= secl_pkg::SYNC_RST[i];
					s3_ff[i] <= secl_pkg::SYNC_RST[i];
					cln_ff[i] <= secl_pkg::SYNC_RST[i];
				end else begin
					s1_ff[i] <= raw[i];
					s2_ff[i] <= s1_ff[i];
					s3_ff[i] <= s2_ff[i];
					if (s2_ff[i] == s3_ff[i]) begin
						cln_ff[i] <= s3_ff[i];
					end
				end
			end
		end
	endgenerate

	// settle timer; straps are taken only once the synchronisers hold them
	always_ff @(posedge clk) begin
		if (rst) begin
			boot_ff <= 3'h0;
			hot_d_ff <= 1'b0;
		end else begin
			hot_d_ff <= cln_ff[11];
			if (boot_ff != secl_pkg::BOOT_END) begin
				boot_ff <= boot_ff + 3'h1;
			end
		end
	end

	assign boot_go = (boot_ff == secl_pkg::BOOT_LAST);
	// a hot reset reloads but keeps the prescaler
	assign ld_start = (boot_go | (cln_ff[11] & ~hot_d_ff)) & (txn_ff == secl_pkg::T_IDLE)
		& secl_pkg::EE_MODE_MASK[cln_ff[9:6]];
	assign dev_byte = {secl_pkg::DEV_FIX, cln_ff[5:2], 1'b0};

	// apb decode: one wait state, reads come from registers
	assign reg_acc = psel & penable & ~pready;
	assign is_mem = (paddr[11:10] == secl_pkg::CFG_WIN);
	assign mapped = is_mem | (paddr == secl_pkg::OFS_CTRL) | (paddr == secl_pkg::OFS_STAT)
		| (paddr == secl_pkg::OFS_SWITCH_CONTROL_REG) | (paddr == secl_pkg::OFS_EEACC);
	// loader writes own the memory port; an apb write there waits a cycle
	assign blocked = reg_acc & pwrite & is_mem & ld_we_ff;
	assign reg_wr = reg_acc & pwrite & ~blocked;
	assign acc_go = reg_wr & (paddr == secl_pkg::OFS_EEACC) & pwdata[secl_pkg::ACC_GO_BIT]
		& (txn_ff == secl_pkg::T_IDLE) & ~ld_start;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_mem) begin
			rd_mux = mem_rdata;
		end else if (paddr == secl_pkg::OFS_CTRL) begin
			rd_mux = {14'h0000, split_ff, ick_ff, master_clock_prescaler};
		end else if (paddr == secl_pkg::OFS_STAT) begin
			rd_mux = {26'h000_0000, (txn_ff != secl_pkg::T_IDLE), stat_ff};
		end else if (paddr == secl_pkg::OFS_SWITCH_CONTROL_REG) begin
			rd_mux = {31'h0000_0000, reset_halt_bit};
		end else if (paddr == secl_pkg::OFS_EEACC) begin
			rd_mux = {(txn_ff != secl_pkg::T_IDLE), acc_done_ff, 5'h00, acc_op_ff,
				acc_rd_ff, ee_addr_ff};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= reg_acc & ~blocked;
			pslverr <= reg_acc & ~blocked & ~mapped;
			prdata <= (reg_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// configuration space; read address comes straight from the setup phase
	assign mem_we = ld_we_ff | (reg_wr & is_mem);
	assign mem_waddr = ld_we_ff ? ld_waddr_ff : paddr[9:2];
	assign mem_wdata = ld_we_ff ? ld_wdata_ff : pwdata;

	secl_cfg_mem u_mem (
		.clk(clk),
		.rst(rst),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(paddr[9:2]),
		.rdata(mem_rdata)
	);

	// control register; the strap load at boot wins over software
	always_ff @(posedge clk) begin
		if (rst) begin
			master_clock_prescaler <= secl_pkg::PRESC_FAST;
			ick_ff <= 1'b0;
			split_ff <= 1'b0;
		end else if (boot_go) begin
			master_clock_prescaler <= cln_ff[10] ? secl_pkg::PRESC_SLOW
				: secl_pkg::PRESC_FAST;
		end else if (reg_wr && paddr == secl_pkg::OFS_CTRL) begin
			master_clock_prescaler <= pwdata[15:0];
			ick_ff <= pwdata[secl_pkg::CTRL_ICK_BIT];
			split_ff <= pwdata[secl_pkg::CTRL_SPLIT_BIT];
		end
	end

	// sticky status, write one to clear, a same-cycle event wins
	assign set_vec = {ev_la_ff, ev_na_ff, ev_unmapped_write_flag_ff, ev_cs_ff, ev_done_ff};
	assign clr_vec = ((reg_wr && paddr == secl_pkg::OFS_STAT) ? pwdata[4:0] : 5'h00)
		| (ld_start ? 5'h01 : 5'h00);
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_ff <= 5'h00;
		end else begin
			stat_ff <= (stat_ff & ~clr_vec) | set_vec;
		end
	end

	// halt bit: software may clear it, a loader abort sets it
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_halt_bit <= 1'b0;
		end else if (ev_halt_ff) begin
			reset_halt_bit <= 1'b1;
		end else if (reg_wr && paddr == secl_pkg::OFS_SWITCH_CONTROL_REG) begin
			reset_halt_bit <= pwdata[0];
		end
	end

	// eeprom programming path for software
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_op_ff <= 1'b0;
			acc_data_ff <= 8'h00;
			acc_done_ff <= 1'b0;
		end else if (acc_go) begin
			acc_op_ff <= pwdata[secl_pkg::ACC_OP_BIT];
			acc_data_ff <= pwdata[23:16];
			acc_done_ff <= 1'b0;
		end else if (ev_acc_ff) begin
			acc_done_ff <= 1'b1;
		end
	end

	// byte command for each transaction step
	always_comb begin
		eng_cmd = secl_pkg::CMD_WRITE;
		eng_wdata = 8'h00;
		eng_ack = 1'b1;
		unique case (txn_ff)
			secl_pkg::T_IDLE: eng_cmd = secl_pkg::CMD_STOP;
			secl_pkg::T_START: eng_cmd = secl_pkg::CMD_START;
			secl_pkg::T_RSTART: eng_cmd = secl_pkg::CMD_START;
			secl_pkg::T_DEVW: eng_wdata = dev_byte;
			secl_pkg::T_AHI: eng_wdata = ee_addr_ff[15:8];
			secl_pkg::T_ALO: eng_wdata = ee_addr_ff[7:0];
			secl_pkg::T_WDATA: eng_wdata = acc_data_ff;
			secl_pkg::T_DEVR: eng_wdata = dev_byte | 8'h01;
			secl_pkg::T_READ: eng_cmd = secl_pkg::CMD_READ;
			secl_pkg::T_LAST: begin
				eng_cmd = secl_pkg::CMD_READ;
				eng_ack = 1'b0;
			end
			secl_pkg::T_STOP: eng_cmd = secl_pkg::CMD_STOP;
		endcase
	end

	assign eng_go = (txn_ff != secl_pkg::T_IDLE) & ~wait_ff & eng_idle;
	assign sum_n = csum_ff + eng_rdata;
	assign blk_idx = blk_addr_ff - secl_pkg::CFG_BASE_DW;

	secl_byte_engine u_eng (
		.clk(clk),
		.rst(rst),
		.presc(master_clock_prescaler),
		.arb_en(~split_ff),
		.cmd_valid(eng_go),
		.cmd(eng_cmd),
		.wdata(eng_wdata),
		.ack_out(eng_ack),
		.scl_i(cln_ff[1]),
		.sda_i(cln_ff[0]),
		.idle(eng_idle),
		.done(eng_done),
		.rdata(eng_rdata),
		.nack(eng_nack),
		.lost(eng_lost),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe)
	);

	// open-drain: only the enables move
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// transaction sequencer and block parser
	always_ff @(posedge clk) begin
		if (rst) begin
			txn_ff <= secl_pkg::T_IDLE;
			prs_ff <= secl_pkg::P_B0;
			ld_mode_ff <= 1'b0;
			wait_ff <= 1'b0;
			ee_addr_ff <= 16'h0000;
			csum_ff <= 8'h00;
			blk_addr_ff <= 14'h0000;
			cnt_ff <= 16'h0000;
			data_ff <= 32'h0000_0000;
			bpos_ff <= 2'h0;
			ld_we_ff <= 1'b0;
			ld_waddr_ff <= 8'h00;
			ld_wdata_ff <= 32'h0000_0000;
			acc_rd_ff <= 8'h00;
			{ev_done_ff, ev_cs_ff, ev_unmapped_write_flag_ff, ev_na_ff, ev_la_ff, ev_halt_ff} <= 6'h00;
			ev_acc_ff <= 1'b0;
		end else begin
			{ev_done_ff, ev_cs_ff, ev_unmapped_write_flag_ff, ev_na_ff, ev_la_ff, ev_halt_ff} <= 6'h00;
			ev_acc_ff <= 1'b0;
			ld_we_ff <= 1'b0;
			if (txn_ff == secl_pkg::T_IDLE) begin
				if (ld_start) begin
					ld_mode_ff <= 1'b1;
					ee_addr_ff <= 16'h0000;
					csum_ff <= 8'h00;
					prs_ff <= secl_pkg::P_B0;
					bpos_ff <= 2'h0;
					txn_ff <= secl_pkg::T_START;
				end else if (acc_go) begin
					ld_mode_ff <= 1'b0;
					ee_addr_ff <= pwdata[15:0];
					txn_ff <= secl_pkg::T_START;
				end
			end else if (eng_go) begin
				wait_ff <= 1'b1;
			end else if (eng_done) begin
				wait_ff <= 1'b0;
				if (eng_lost) begin
					// bus belongs to the winner now, so no stop of our own
					txn_ff <= secl_pkg::T_IDLE;
					ev_la_ff <= 1'b1;
					ev_halt_ff <= ld_mode_ff;
					ev_done_ff <= ld_mode_ff;
				end else if (eng_nack && eng_cmd == secl_pkg::CMD_WRITE) begin
					txn_ff <= secl_pkg::T_STOP;
					ev_na_ff <= 1'b1;
					ev_halt_ff <= ld_mode_ff;
				end else begin
					unique case (txn_ff)
						secl_pkg::T_IDLE: txn_ff <= secl_pkg::T_IDLE;
						secl_pkg::T_START: txn_ff <= secl_pkg::T_DEVW;
						secl_pkg::T_DEVW: txn_ff <= secl_pkg::T_AHI;
						secl_pkg::T_AHI: txn_ff <= secl_pkg::T_ALO;
						secl_pkg::T_ALO: txn_ff <= (!ld_mode_ff && acc_op_ff) ? secl_pkg::T_WDATA
							: secl_pkg::T_RSTART;
						secl_pkg::T_WDATA: txn_ff <= secl_pkg::T_STOP;
						secl_pkg::T_RSTART: txn_ff <= secl_pkg::T_DEVR;
						secl_pkg::T_DEVR: txn_ff <= ld_mode_ff ? secl_pkg::T_READ
							: secl_pkg::T_LAST;
						secl_pkg::T_READ: begin
							csum_ff <= sum_n;
							ee_addr_ff <= ee_addr_ff + 16'h0001;
							unique case (prs_ff)
								secl_pkg::P_B0: begin
									blk_addr_ff[7:0] <= eng_rdata;
									prs_ff <= secl_pkg::P_B1;
								end
								secl_pkg::P_B1: begin
									blk_addr_ff[13:8] <= eng_rdata[5:0];
									unique case (eng_rdata[7:6])
										secl_pkg::TYPE_SINGLE: begin
											cnt_ff <= 16'h0001;
											prs_ff <= secl_pkg::P_DATA;
										end
										secl_pkg::TYPE_SEQ: prs_ff <= secl_pkg::P_CNT0;
										secl_pkg::TYPE_BAD: begin
											ev_cs_ff <= 1'b1;
											ev_halt_ff <= 1'b1;
											txn_ff <= secl_pkg::T_LAST;
										end
										secl_pkg::TYPE_DONE: begin
											// image sum closes at all ones
											if (!ick_ff && sum_n != secl_pkg::CSUM_GOOD) begin
												ev_cs_ff <= 1'b1;
												ev_halt_ff <= 1'b1;
											end
											txn_ff <= secl_pkg::T_LAST;
										end
									endcase
								end
								secl_pkg::P_CNT0: begin
									cnt_ff[7:0] <= eng_rdata;
									prs_ff <= secl_pkg::P_CNT1;
								end
								secl_pkg::P_CNT1: begin
									cnt_ff[15:8] <= eng_rdata;
									// a zero count carries no data
									prs_ff <= ({eng_rdata, cnt_ff[7:0]} == 16'h0000) ? secl_pkg::P_B0
										: secl_pkg::P_DATA;
								end
								secl_pkg::P_DATA: begin
									data_ff <= {eng_rdata, data_ff[31:8]};
									bpos_ff <= bpos_ff + 2'h1;
									if (bpos_ff == 2'h3) begin
										if (blk_idx < secl_pkg::CFG_DEPTH) begin
											ld_we_ff <= 1'b1;
										end else begin
											ev_unmapped_write_flag_ff <= 1'b1;
										end
										ld_waddr_ff <= blk_idx[7:0];
										ld_wdata_ff <= {eng_rdata, data_ff[31:8]};
										blk_addr_ff <= blk_addr_ff + 14'h0001;
										cnt_ff <= cnt_ff - 16'h0001;
										if (cnt_ff == 16'h0001) begin
											prs_ff <= secl_pkg::P_B0;
										end
									end
								end
							endcase
							if (ee_addr_ff == secl_pkg::EE_LAST_ADDR) begin
								txn_ff <= secl_pkg::T_LAST;
							end
						end
						secl_pkg::T_LAST: begin
							// discarded byte for the loader, nacked to free the bus
							if (!ld_mode_ff) begin
								acc_rd_ff <= eng_rdata;
							end
							txn_ff <= secl_pkg::T_STOP;
						end
						secl_pkg::T_STOP: begin
							txn_ff <= secl_pkg::T_IDLE;
							ev_done_ff <= ld_mode_ff;
							ev_acc_ff <= ~ld_mode_ff;
						end
					endcase
				end
			end
		end
	end
endmodule : secl_loader_top

// *** verilog/secl_pkg.sv ***
package secl_pkg;

	// clock and bus rates
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SLOW_HZ = 100_000;
	localparam int unsigned FAST_HZ = 400_000;
	// quarter bit time in clocks, rounded up so the bus never runs fast
	localparam logic [15:0] PRESC_SLOW = 16'((CLK_HZ + 4 * SLOW_HZ - 1) / (4 * SLOW_HZ));
	localparam logic [15:0] PRESC_FAST = 16'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));

	// register byte offsets on the apb side
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_SWITCH_CONTROL_REG = 12'h008;
	localparam logic [11:0] OFS_EEACC = 12'h00c;
	localparam logic [1:0] CFG_WIN = 2'h1;

	// control register fields
	localparam int CTRL_ICK_BIT = 16;
	localparam int CTRL_SPLIT_BIT = 17;
	// status register fields
	localparam int ST_DONE = 0;
	localparam int ST_CSERR = 1;
	localparam int ST_UNMAPPED_WRITE_FLAG = 2;
	localparam int ST_NAERR = 3;
	localparam int ST_LAERR = 4;
	localparam int ST_BUSY = 5;
	// eeprom access register fields
	localparam int ACC_OP_BIT = 24;
	localparam int ACC_DONE_BIT = 30;
	localparam int ACC_GO_BIT = 31;

	// configuration space held in the block
	localparam int CFG_AW = 8;
	localparam logic [13:0] CFG_BASE_DW = 14'h0000;
	localparam logic [13:0] CFG_DEPTH = 14'h0100;

	// eeprom device address, bits 7..5
	localparam logic [2:0] DEV_FIX = 3'h5;
	localparam logic [15:0] EE_LAST_ADDR = 16'hffff;
	// operating modes that include eeprom loading, one bit per mode
	localparam logic [15:0] EE_MODE_MASK = 16'h0007;

	// block type codes
	localparam logic [1:0] TYPE_SINGLE = 2'h0;
	localparam logic [1:0] TYPE_SEQ = 2'h1;
	localparam logic [1:0] TYPE_BAD = 2'h2;
	localparam logic [1:0] TYPE_DONE = 2'h3;
	localparam logic [7:0] CSUM_GOOD = 8'hff;

	// power-up settle time for the pin synchronisers
	localparam logic [2:0] BOOT_LAST = 3'h5;
	localparam logic [2:0] BOOT_END = 3'h6;
	localparam int SYNC_W = 12;
	localparam logic [11:0] SYNC_RST = 12'h003;

	typedef enum logic [1:0] {
		CMD_START = 2'b00,
		CMD_STOP = 2'b01,
		CMD_WRITE = 2'b10,
		CMD_READ = 2'b11
	} secl_cmd_t;

	typedef enum logic [3:0] {
		T_IDLE = 4'b0000,
		T_START = 4'b0001,
		T_DEVW = 4'b0010,
		T_AHI = 4'b0011,
		T_ALO = 4'b0100,
		T_WDATA = 4'b0101,
		T_RSTART = 4'b0110,
		T_DEVR = 4'b0111,
		T_READ = 4'b1000,
		T_LAST = 4'b1001,
		T_STOP = 4'b1010
	} secl_txn_t;

	typedef enum logic [2:0] {
		P_B0 = 3'b000,
		P_B1 = 3'b001,
		P_CNT0 = 3'b010,
		P_CNT1 = 3'b011,
		P_DATA = 3'b100
	} secl_prs_t;

endpackage : secl_pkg

// *** verilog/secl_cfg_mem.sv ***
`timescale 1ns/1ps
module secl_cfg_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [7:0] raddr,
	output logic [31:0] rdata
);
	logic [31:0] mem_ff [0:255];

	// whole double words only, no byte lanes
	always_ff @(posedge clk) begin
		if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	// registered read, one cycle after the address
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= mem_ff[raddr];
		end
	end
endmodule : secl_cfg_mem

// *** verilog/secl_byte_engine.sv ***
`timescale 1ns/1ps
module secl_byte_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] presc,
	input wire logic arb_en,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd,
	input wire logic [7:0] wdata,
	input wire logic ack_out,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic idle,
	output logic done,
	output logic [7:0] rdata,
	output logic nack,
	output logic lost,
	output logic scl_oe,
	output logic sda_oe
);
	logic run_ff;
	logic [15:0] tick_ff;
	logic [1:0] ph_ff;
	logic [3:0] bit_ff;
	logic [8:0] sh_ff;
	logic [1:0] op_ff;
	logic sda_lvl;
	logic scl_lvl;
	logic stretch;
	logic tick;
	logic last_bit;
	logic lost_now;

	assign idle = ~run_ff;

	// wanted line levels per quarter phase
	always_comb begin
		sda_lvl = sh_ff[8];
		scl_lvl = (ph_ff == 2'd1) || (ph_ff == 2'd2);
		case (op_ff)
			secl_pkg::CMD_START: sda_lvl = ~ph_ff[1];
			secl_pkg::CMD_STOP: begin
				sda_lvl = ph_ff[1];
				scl_lvl = (ph_ff != 2'd0);
			end
			secl_pkg::CMD_WRITE: sda_lvl = sh_ff[8];
			secl_pkg::CMD_READ: sda_lvl = sh_ff[8];
		endcase
	end

	// a slave holding scl low freezes the high phase
	assign stretch = scl_lvl & ~scl_i & (ph_ff == 2'd1);
	assign tick = run_ff & ((tick_ff + 16'd1) >= presc) & ~stretch;
	assign last_bit = ~op_ff[1] | (bit_ff == 4'd8);
	// released sda seen low while we send data: another master won
	assign lost_now = tick & arb_en & (ph_ff == 2'd2) & (op_ff == secl_pkg::CMD_WRITE)
		& (bit_ff != 4'd8) & sh_ff[8] & ~sda_i;

	// quarter bit timer
	always_ff @(posedge clk) begin
		if (rst || !run_ff || tick) begin
			tick_ff <= 16'h0000;
		end else if (!stretch) begin
			tick_ff <= tick_ff + 16'd1;
		end
	end

	// bit sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			run_ff <= 1'b0;
			ph_ff <= 2'd0;
			bit_ff <= 4'd0;
			sh_ff <= 9'h1ff;
			op_ff <= secl_pkg::CMD_STOP;
			done <= 1'b0;
			lost <= 1'b0;
			nack <= 1'b0;
			rdata <= 8'h00;
		end else begin
			done <= 1'b0;
			lost <= 1'b0;
			if (!run_ff) begin
				if (cmd_valid) begin
					run_ff <= 1'b1;
					ph_ff <= 2'd0;
					bit_ff <= 4'd0;
					op_ff <= cmd;
					nack <= 1'b0;
					// ack slot of a read carries our ack, of a write is released
					sh_ff <= (cmd == secl_pkg::CMD_READ) ? {8'hff, ~ack_out} : {wdata, 1'b1};
				end
			end else if (lost_now) begin
				run_ff <= 1'b0;
				lost <= 1'b1;
				done <= 1'b1;
			end else if (tick) begin
				ph_ff <= ph_ff + 2'd1;
				if (ph_ff == 2'd2 && op_ff[1]) begin
					if (bit_ff == 4'd8) begin
						nack <= sda_i;
					end else begin
						rdata <= {rdata[6:0], sda_i};
					end
				end
				if (ph_ff == 2'd3) begin
					sh_ff <= {sh_ff[7:0], 1'b1};
					bit_ff <= bit_ff + 4'd1;
					if (last_bit) begin
						run_ff <= 1'b0;
						done <= 1'b1;
					end
				end
			end
		end
	end

	// open-drain drive; lines keep their level between bytes
	always_ff @(posedge clk) begin
		if (rst || lost_now) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (run_ff) begin
			scl_oe <= ~scl_lvl;
			sda_oe <= ~sda_lvl;
		end
	end
endmodule : secl_byte_engine

// *** sim/secl_loader_assertions.sv ***
`timescale 1ns/1ps
module secl_loader_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic reset_halt_bit
);
	logic halt_wr;
	// software write of the halt register, held until pready
	assign halt_wr = psel && penable && pwrite && paddr == 12'h008;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// one wait state, two when the loader holds the memory
	a_ready_wait: assert property (psel && penable && !$past(penable) |-> ##[1:2] pready)
		else $error("late pready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("long pready");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad slverr");
	a_map_ok: assert property (pready && paddr[11:4] == 8'h00 |-> !pslverr)
		else $error("slverr on mapped register");
	a_data_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata without pready");
	// a reset in mid-frame must still free the bus
	a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> !pready && !scl_oe && !sda_oe && !reset_halt_bit) else $error("reset");
	a_boot_quiet: assert property ($fell(rst) |-> (!scl_oe && !sda_oe) [*4])
		else $error("bus used before straps");
	a_halt_clear: assert property ($fell(reset_halt_bit) |-> $past(halt_wr))
		else $error("halt dropped by itself");
endmodule : secl_loader_assertions
bind secl_loader_top secl_loader_assertions chk_u (.clk(clk), .rst(rst), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scl_oe(scl_oe), .sda_oe(sda_oe), .reset_halt_bit(reset_halt_bit));

// *** sim/secl_ee_model.sv ***
`timescale 1ns/1ps
module secl_ee_model #(parameter logic [6:0] DEV = 7'h00) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	logic [7:0] mem [0:63];
	logic [7:0] sr;
	logic [15:0] ptr;
	logic [3:0] cnt;
	logic [1:0] ph;
	logic rd;
	logic act;
	// blank part reads all ones
	initial begin
		sda_oe = 1'b0;
		act = 1'b0;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// start and stop: sda moves while scl is high
	always @(negedge sda) if (scl === 1'b1) begin
		{act, cnt, ph, rd} = {1'b1, 4'h0, 2'h0, 1'b0};
	end
	always @(posedge sda) if (scl === 1'b1) act = 1'b0;
	// bits taken on rising scl, ninth bit is the ack
	always @(posedge scl) if (act) begin
		if (cnt != 4'h8) begin
			sr = {sr[6:0], sda};
			cnt++;
		end else begin
			if (rd && !sda_oe && sda) act = 1'b0;
			else if (rd && !sda_oe) ptr++;
			cnt = 4'h0;
		end
	end
	// sda only changes while scl is low, so no false start
	always @(negedge scl) if (act) begin
		if (cnt == 4'h8 && !rd) begin
			sda_oe = (ph != 2'h0) || (sr[7:1] == DEV);
			act = sda_oe;
			if (ph == 2'h0) rd = sr[0];
			if (ph == 2'h1) ptr[15:8] = sr;
			if (ph == 2'h2) ptr[7:0] = sr;
			if (ph == 2'h3) mem[ptr[5:0]] = sr;
			if (ph == 2'h3) ptr++;
			if (ph != 2'h3) ph++;
		end else sda_oe = rd && cnt != 4'h8 && !mem[ptr[5:0]][3'(7 - cnt)];
	end
endmodule : secl_ee_model

// *** sim/smbus_eeprom_config_loader_tb.sv ***
`timescale 1ns/1ps
module smbus_eeprom_config_loader_tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, strap = 1, hot = 0, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [3:0] mode = 4'h3, pins = 4'ha;
	logic pready, pslverr, scl_oe, sda_oe, halt, ee_oe;
	logic [7:0] img [0:25];
	logic [7:0] sum;
	int err_total = 0, n_checks = 0;
	// open-drain lines with pull-ups
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | ee_oe);
	always #2 clk = ~clk;
	secl_loader_top dut_u (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_slow_mode_strap(strap), .switch_operating_mode(mode),
		.master_eeprom_addr_pins(pins), .hot_reset(hot), .scl_in(scl), .scl_out(),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .reset_halt_bit(halt));
	secl_ee_model #(.DEV(7'h5a)) ee_u (.scl(scl), .sda(sda), .sda_oe(ee_oe));
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task tmo;
		$display("Error %0t: timeout", $time);
		err_total++;
		end_sim();
	endtask : tmo
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// hold the request until pready is seen at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		if (n >= 50) tmo();
	endtask : apb
	task do_rst(input logic s);
		{strap, rst} <= {s, 1'b1};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (20) @(posedge clk);
	endtask : do_rst
	// clear status and halt, reload through hot reset, wait for done
	task load(input logic [31:0] ctrl, input logic [4:0] st, input logic h);
		int n;
		apb(1'b1, 12'h008, '0);
		apb(1'b1, 12'h004, 32'h0000_001f);
		apb(1'b1, 12'h000, ctrl);
		hot <= 1'b1;
		repeat (8) @(posedge clk);
		hot <= 1'b0;
		n = 0;
		do begin
			apb(1'b0, 12'h004, '0);
			n++;
		end while (q[secl_pkg::ST_DONE] !== 1'b1 && n < 4000);
		if (n >= 4000) tmo();
		chk(32'(q[4:0]), 32'(st));
		chk(32'(halt), 32'(h));
		apb(1'b0, 12'h008, '0);
		chk(32'(q[0]), 32'(h));
	endtask : load
	// software eeprom access, then poll the access register until its done bit
	task acc(input logic [31:0] cmd);
		int n;
		apb(1'b1, secl_pkg::OFS_EEACC, cmd);
		n = 0;
		do begin
			apb(1'b0, secl_pkg::OFS_EEACC, '0);
			n++;
		end while (q[secl_pkg::ACC_DONE_BIT] !== 1'b1 && n < 2000);
		if (n >= 2000) tmo();
	endtask : acc
	initial begin
		do_rst(1'b1);
		apb(1'b0, secl_pkg::OFS_CTRL, '0);
		chk(32'(q[15:0]), 32'(secl_pkg::PRESC_SLOW));
		apb(1'b0, secl_pkg::OFS_STAT, '0);
		chk(32'(q[secl_pkg::ST_BUSY]), 32'h0);
		do_rst(1'b0);
		apb(1'b0, secl_pkg::OFS_CTRL, '0);
		chk(32'(q[15:0]), 32'(secl_pkg::PRESC_FAST));
		apb(1'b0, 12'h010, '0);
		chk(32'(e), 32'h1);
		mode <= 4'h0;
		// single to dword 5, two sequential at 0x10, unmapped single, done
		img = '{8'h05, 8'h00, 8'h44, 8'h33, 8'h22, 8'h11, 8'h10, 8'h40, 8'h02, 8'h00,
			8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'h00, 8'h02,
			8'hde, 8'had, 8'hbe, 8'hef, 8'h00, 8'hc0};
		sum = 8'h00;
		foreach (img[i]) sum += img[i];
		img[24] = ~sum;
		foreach (img[i]) ee_u.mem[i] = img[i];
		load(32'h0002_0002, 5'h05, 1'b0);
		apb(1'b0, 12'h414, '0);
		chk(q, 32'h1122_3344);
		apb(1'b0, 12'h440, '0);
		chk(q, 32'ha3a2_a1a0);
		apb(1'b0, 12'h444, '0);
		chk(q, 32'hb3b2_b1b0);
		ee_u.mem[24] = img[24] ^ 8'h01;
		load(32'h0002_0002, 5'h07, 1'b1);
		load(32'h0003_0002, 5'h05, 1'b0);
		ee_u.mem[1] = 8'h80;
		load(32'h0000_0002, 5'h03, 1'b1);
		// wrong address pins: nobody acks the device byte
		pins <= 4'hb;
		load(32'h0002_0002, 5'h09, 1'b1);
		pins <= 4'ha;
		// write one byte through the programming path, then read it back
		acc(32'h815c_0030);
		chk(32'(ee_u.mem[48]), 32'h0000_005c);
		acc(32'h8000_0030);
		chk(32'(q[23:16]), 32'h0000_005c);
		chk(32'(q[31]), 32'h0);
		end_sim();
	end
endmodule : smbus_eeprom_config_loader_tb
